// ---- bench/hs_machine_model.sv ----
// -----------------------------------------------------------------
// Machine axis facing the homing sequencer
// -----------------------------------------------------------------
// The shaft moves by the commanded speed each cycle with no inertia. Any
// overshoot past a switch edge is therefore only the sequencer's own latency.
module hs_machine_model
(
   input  wire logic               i_clock,
   input  wire logic               i_load,
   input  wire logic signed [15:0] i_load_pos,
   input  wire logic        [31:0] i_speed_ref,
   input  wire logic               i_dir_reverse,
   output logic                    o_negative_overtravel_input,
   output logic                    o_positive_overtravel_input,
   output logic                    o_home_switch_input,
   output logic                    o_index_pulse,
   output logic signed      [15:0] o_last_index_pos
);
   timeunit 1ns;
   timeprecision 1ps;

   logic signed [15:0] pos_reg;
   logic               index_q_reg;

   // Step the shaft. A load puts it at the start point of a test.
   always_ff @(posedge i_clock) begin
      if (i_load) begin
         pos_reg <= i_load_pos;
      end else if (i_dir_reverse) begin
         pos_reg <= pos_reg - $signed(i_speed_ref[15:0]);
      end else begin
         pos_reg <= pos_reg + $signed(i_speed_ref[15:0]);
      end
   end

   // Limits at 0 and 200, home cam from 96 to 135, index mark every 16 at offset 8.
   assign o_negative_overtravel_input = (pos_reg <= 16'sh0000);
   assign o_positive_overtravel_input = (pos_reg >= 16'sh00C8);
   assign o_home_switch_input         = (pos_reg >= 16'sh0060) && (pos_reg <= 16'sh0087);
   assign o_index_pulse               = (pos_reg[3:0] == 4'h8);

   // Keep the place of the last index mark crossed; that is the home found.
   always_ff @(posedge i_clock) begin
      index_q_reg <= o_index_pulse;
      if (i_load) begin
         o_last_index_pos <= 16'sh7FFF;
      end else if (o_index_pulse && !index_q_reg) begin
         o_last_index_pos <= pos_reg;
      end
   end
endmodule

// ---- bench/hs_sequencer_tb.sv ----
`define HS_CHK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("CHECK FAILED %s expected %0h seen %0h", what, (exp), (got)); \
      end \
   end

module hs_sequencer_tb
   import hs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // -----------------------------------------------------------------
   // Stimulus table: method, start point, first move, home expected
   // -----------------------------------------------------------------
   typedef struct packed {
      logic        [7:0]  method;
      logic signed [15:0] start_pos;
      logic               start_rev;
      logic               start_fast;
      logic signed [15:0] home_pos;
      logic               end_rev;
   } hs_case_type;

   localparam logic [31:0] SPD_HI   = 32'h00000002;
   localparam logic [31:0] SPD_LO   = 32'h00000001;
   localparam logic [31:0] PROF_ACC = 32'h000003E8;
   localparam hs_case_type ROWS [18] = '{
      '{8'h01, 16'h0032, 1'b1, 1'b1, 16'h0008, 1'b0},
      '{8'h01, 16'hFFF6, 1'b0, 1'b0, 16'h0008, 1'b0},
      '{8'h02, 16'h0096, 1'b0, 1'b1, 16'h00B8, 1'b1},
      '{8'h02, 16'h00D2, 1'b1, 1'b0, 16'h00B8, 1'b1},
      '{8'h03, 16'h0032, 1'b0, 1'b1, 16'h0058, 1'b1},
      '{8'h03, 16'h0076, 1'b1, 1'b0, 16'h0058, 1'b1},
      '{8'h04, 16'h0032, 1'b0, 1'b1, 16'h0068, 1'b0},
      '{8'h04, 16'h0076, 1'b1, 1'b0, 16'h0068, 1'b0},
      '{8'h05, 16'h00A0, 1'b1, 1'b1, 16'h0098, 1'b0},
      '{8'h05, 16'h0076, 1'b0, 1'b0, 16'h0098, 1'b0},
      '{8'h06, 16'h00A0, 1'b1, 1'b1, 16'h0078, 1'b1},
      '{8'h06, 16'h0076, 1'b0, 1'b0, 16'h0078, 1'b1},
      '{8'h07, 16'h0032, 1'b0, 1'b1, 16'h0058, 1'b1},
      '{8'h07, 16'h0076, 1'b1, 1'b0, 16'h0058, 1'b1},
      '{8'h07, 16'h0096, 1'b0, 1'b1, 16'h0058, 1'b1},
      '{8'h08, 16'h0032, 1'b0, 1'b1, 16'h0068, 1'b0},
      '{8'h08, 16'h0076, 1'b1, 1'b0, 16'h0068, 1'b0},
      '{8'h08, 16'h0096, 1'b0, 1'b1, 16'h0068, 1'b0}
   };

   logic               clock = 1'b0;
   logic               rst_b = 1'b0;
   logic               neg_lim, pos_lim, home_sw, index_p;
   logic        [7:0]  method = 8'h01;
   logic               start = 1'b0;
   logic               abort = 1'b0;
   logic               clk_en = 1'b1;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic        [15:0] oidx = 16'h0000;
   logic        [31:0] wdata = 32'h00000000;
   logic        [31:0] rdata, ceil, hacc, spd;
   logic               ack, unm, dir_rev, act, done, merr;
   logic               load = 1'b1;
   logic signed [15:0] load_pos = 16'h0032;
   logic signed [15:0] last_idx;
   logic        [31:0] got_rd;
   logic               got_ack, got_unm;
   int                 miscompares = 0;
   int                 samples_checked = 0;
   int                 cycles = 0;

   always #5 clock = ~clock;

   hs_sequencer i_dut (
      .i_clock(clock), .i_rst_b(rst_b), .i_clock_en(clk_en),
      .i_negative_overtravel_input(neg_lim), .i_positive_overtravel_input(pos_lim),
      .i_home_switch_input(home_sw), .i_index_pulse(index_p),
      .i_homing_method_select(method), .i_switch_search_speed(SPD_HI),
      .i_index_search_speed(SPD_LO), .i_profile_acceleration(PROF_ACC),
      .i_homing_start(start), .i_homing_abort(abort), .i_obj_write(wr), .i_obj_read(rd),
      .i_obj_index(oidx), .i_obj_wdata(wdata), .o_obj_rdata(rdata), .o_obj_ack(ack),
      .o_obj_unmapped(unm), .o_accel_ceiling(ceil), .o_homing_acceleration(hacc),
      .o_speed_ref(spd), .o_dir_reverse(dir_rev), .o_homing_active(act),
      .o_homing_done(done), .o_method_error(merr)
   );

   hs_machine_model i_model (
      .i_clock(clock), .i_load(load), .i_load_pos(load_pos), .i_speed_ref(spd),
      .i_dir_reverse(dir_rev), .o_negative_overtravel_input(neg_lim),
      .o_positive_overtravel_input(pos_lim), .o_home_switch_input(home_sw),
      .o_index_pulse(index_p), .o_last_index_pos(last_idx)
   );

   // -----------------------------------------------------------------
   // Shared tasks
   // -----------------------------------------------------------------
   // Print the counts and the verdict, then stop.
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // One object access; the answer is taken in the ack cycle, then a quiet cycle follows.
   task automatic obj(input logic w, input logic [15:0] ix, input logic [31:0] d);
      wr = w;
      rd = !w;
      oidx = ix;
      wdata = d;
      @(negedge clock);
      got_ack = ack;
      got_unm = unm;
      got_rd = rdata;
      wr = 1'b0;
      rd = 1'b0;
      @(negedge clock);
   endtask

   // Park the shaft, let the synchronisers settle, then pulse start for one cycle.
   task automatic run_start(input logic [7:0] m, input logic signed [15:0] p);
      method = m;
      load_pos = p;
      load = 1'b1;
      @(negedge clock);
      load = 1'b0;
      repeat (6) @(negedge clock);
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
   endtask

   // A hang is cut short here; the ceiling is well above the sum of all tests.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         $display("timeout at cycle %0d", cycles);
         close_out();
      end
   end

   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial begin
      int         n;
      logic [7:0] bad [3];
      bad = '{8'h00, 8'h09, 8'hFF};
      repeat (6) @(negedge clock);
      rst_b = 1'b1;
      for (int r = 0; r < 18; r++) begin
         run_start(ROWS[r].method, ROWS[r].start_pos);
         repeat (2) @(negedge clock);
         `HS_CHK("first speed", (ROWS[r].start_fast ? SPD_HI : SPD_LO), spd)
         `HS_CHK("first direction", ROWS[r].start_rev, dir_rev)
         n = 0;
         while (done !== 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
         end
         `HS_CHK("done", 1'b1, done)
         `HS_CHK("home index", ROWS[r].home_pos, last_idx)
         `HS_CHK("last direction", ROWS[r].end_rev, dir_rev)
         `HS_CHK("active after done", 1'b0, act)
         repeat (4) @(negedge clock);
         $display("row %0d done", r);
      end
      // Ceiling written while running, then reset in mid-run.
      run_start(HS_METHOD_HOME_FWD, 16'h0032);
      obj(1'b1, HS_ACCEL_CEILING_INDEX, 32'h000003E7);
      `HS_CHK("live clamp", 32'h000003E7, hacc)
      `HS_CHK("still active", 1'b1, act)
      rst_b = 1'b0;
      @(negedge clock);
      `HS_CHK("reset speed", 32'h00000000, spd)
      `HS_CHK("reset active", 1'b0, act)
      `HS_CHK("reset ceiling", HS_ACCEL_CEILING_RESET, ceil)
      rst_b = 1'b1;
      repeat (2) @(negedge clock);
      `HS_CHK("default clamp", PROF_ACC, hacc)
      $display("test reset done");
      // Object port: default, zero write, full range, boundary clamp, unmapped index.
      obj(1'b0, HS_ACCEL_CEILING_INDEX, HS_ZERO_WORD);
      `HS_CHK("read ack", 1'b1, got_ack)
      `HS_CHK("read default", HS_ACCEL_CEILING_RESET, got_rd)
      obj(1'b1, HS_ACCEL_CEILING_INDEX, HS_ZERO_WORD);
      `HS_CHK("zero stored", HS_ACCEL_CEILING_MIN, ceil)
      `HS_CHK("clamp to one", HS_ACCEL_CEILING_MIN, hacc)
      obj(1'b1, HS_ACCEL_CEILING_INDEX, 32'hFFFFFFFF);
      obj(1'b0, HS_ACCEL_CEILING_INDEX, HS_ZERO_WORD);
      `HS_CHK("read full", 32'hFFFFFFFF, got_rd)
      `HS_CHK("no clamp", PROF_ACC, hacc)
      obj(1'b1, HS_ACCEL_CEILING_INDEX, 32'h000003E7);
      `HS_CHK("edge clamp", 32'h000003E7, hacc)
      obj(1'b1, 16'h6083, 32'h00000007);
      `HS_CHK("unmapped flag", 1'b1, got_unm)
      `HS_CHK("unmapped kept", 32'h000003E7, ceil)
      obj(1'b0, 16'h6083, HS_ZERO_WORD);
      `HS_CHK("unmapped data", 32'h00000000, got_rd)
      $display("test objects done");
      // Unsupported method codes leave the sequencer idle.
      foreach (bad[k]) begin
         run_start(bad[k], 16'h0032);
         @(negedge clock);
         `HS_CHK("method error", 1'b1, merr)
         `HS_CHK("stays idle", 1'b0, act)
      end
      $display("test methods done");
      // Abort in mid-search, after a pause with the clock enable low.
      run_start(HS_METHOD_HOME_FWD, 16'h0032);
      repeat (2) @(negedge clock);
      clk_en = 1'b0;
      obj(1'b1, HS_ACCEL_CEILING_INDEX, 32'h00000005);
      `HS_CHK("frozen ack", 1'b0, got_ack)
      `HS_CHK("frozen ceiling", 32'h000003E7, ceil)
      `HS_CHK("frozen speed", SPD_HI, spd)
      `HS_CHK("frozen active", 1'b1, act)
      clk_en = 1'b1;
      abort = 1'b1;
      repeat (2) @(negedge clock);
      `HS_CHK("abort idle", 1'b0, act)
      abort = 1'b0;
      $display("test abort done");
      close_out();
   end
endmodule

// ---- rtl/hs_sequencer.sv ----
module hs_sequencer
   import hs_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_clock_en,
   input  wire logic        i_negative_overtravel_input,
   input  wire logic        i_positive_overtravel_input,
   input  wire logic        i_home_switch_input,
   input  wire logic        i_index_pulse,
   input  wire logic [7:0]  i_homing_method_select,
   input  wire logic [31:0] i_switch_search_speed,
   input  wire logic [31:0] i_index_search_speed,
   input  wire logic [31:0] i_profile_acceleration,
   input  wire logic        i_homing_start,
   input  wire logic        i_homing_abort,
   input  wire logic        i_obj_write,
   input  wire logic        i_obj_read,
   input  wire logic [15:0] i_obj_index,
   input  wire logic [31:0] i_obj_wdata,
   output logic      [31:0] o_obj_rdata,
   output logic             o_obj_ack,
   output logic             o_obj_unmapped,
   output logic      [31:0] o_accel_ceiling,
   output logic      [31:0] o_homing_acceleration,
   output logic      [31:0] o_speed_ref,
   output logic             o_dir_reverse,
   output logic             o_homing_active,
   output logic             o_homing_done,
   output logic             o_method_error
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [31:0]            accel_ceiling_reg;
   logic [HS_IN_COUNT-1:0] sync1_reg;
   logic [HS_IN_COUNT-1:0] sync2_reg;
   logic [HS_IN_COUNT-1:0] prev_reg;
   logic [HS_IN_COUNT-1:0] rise;
   logic [HS_IN_COUNT-1:0] fall;
   hs_state_type           state_reg;
   hs_state_type           state_next;
   logic                   dir_reg;
   logic                   dir_next;
   logic                   limit_path_reg;
   logic                   limit_path_next;
   logic                   done_reg;
   logic                   error_reg;
   logic                   method_ok;
   logic                   fast_reverse;
   logic                   decel_level;
   logic                   decel_rise;
   logic                   decel_fall;
   logic                   watch_limit;
   logic                   two_stage;
   logic                   ceiling_hit;
   logic                   obj_sel;

   // -----------------------------------------------------------------
   // Acceleration ceiling object
   // -----------------------------------------------------------------
   assign obj_sel = (i_obj_index == HS_ACCEL_CEILING_INDEX);

   // A zero would freeze every ramp, so it is replaced by the smallest legal rate.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         accel_ceiling_reg <= HS_ACCEL_CEILING_RESET;
      end else if (i_clock_en && i_obj_write && obj_sel) begin
         if (i_obj_wdata == HS_ZERO_WORD) begin
            accel_ceiling_reg <= HS_ACCEL_CEILING_MIN;
         end else begin
            accel_ceiling_reg <= i_obj_wdata;
         end
      end
   end

   // Every access made with the clock enable high is answered in the next cycle; an unknown index reads zero.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_obj_rdata    <= HS_ZERO_WORD;
         o_obj_ack      <= 1'b0;
         o_obj_unmapped <= 1'b0;
      end else if (i_clock_en) begin
         o_obj_ack      <= i_obj_write | i_obj_read;
         o_obj_unmapped <= (i_obj_write | i_obj_read) & ~obj_sel;
         if (i_obj_read && obj_sel) begin
            o_obj_rdata <= accel_ceiling_reg;
         end else begin
            o_obj_rdata <= HS_ZERO_WORD;
         end
      end
   end

   assign o_accel_ceiling = accel_ceiling_reg;

   // -----------------------------------------------------------------
   // Input synchronisers and edge detection
   // -----------------------------------------------------------------
   // The first stage feeds only the second; edges come from stage two and its history.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync1_reg <= HS_IN_RESET;
         sync2_reg <= HS_IN_RESET;
         prev_reg  <= HS_IN_RESET;
      end else if (i_clock_en) begin
         sync1_reg <= {i_index_pulse, i_home_switch_input,
                       i_positive_overtravel_input, i_negative_overtravel_input};
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   // Each edge is high for one enabled cycle only, so one step consumes it once.
   assign rise = sync2_reg & ~prev_reg;
   assign fall = ~sync2_reg & prev_reg;

   // -----------------------------------------------------------------
   // Method decode
   // -----------------------------------------------------------------
   // Methods 1 and 2 decelerate on a limit switch, the rest on the home switch.
   always_comb begin
      method_ok    = 1'b1;
      fast_reverse = 1'b0;
      decel_level  = sync2_reg[HS_IN_HOME];
      decel_rise   = rise[HS_IN_HOME];
      decel_fall   = fall[HS_IN_HOME];
      watch_limit  = 1'b0;
      two_stage    = 1'b0;
      unique case (i_homing_method_select)
         HS_METHOD_NEG_LIMIT: begin
            fast_reverse = 1'b1;
            decel_level  = sync2_reg[HS_IN_NEG];
            decel_rise   = rise[HS_IN_NEG];
            decel_fall   = fall[HS_IN_NEG];
         end
         HS_METHOD_POS_LIMIT: begin
            decel_level  = sync2_reg[HS_IN_POS];
            decel_rise   = rise[HS_IN_POS];
            decel_fall   = fall[HS_IN_POS];
         end
         HS_METHOD_HOME_FWD: begin
            fast_reverse = 1'b0;
         end
         HS_METHOD_HOME_FWD_2: begin
            two_stage    = 1'b1;
         end
         HS_METHOD_HOME_REV: begin
            fast_reverse = 1'b1;
         end
         HS_METHOD_HOME_REV_2: begin
            fast_reverse = 1'b1;
            two_stage    = 1'b1;
         end
         HS_METHOD_HOME_LIM: begin
            watch_limit  = 1'b1;
            two_stage    = limit_path_reg;
         end
         HS_METHOD_HOME_LIM_2: begin
            watch_limit  = 1'b1;
            two_stage    = 1'b1;
         end
         default: begin
            method_ok    = 1'b0;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // Sequence state machine
   // -----------------------------------------------------------------
   // Each slow switch pass reverses direction, except the slow pass that follows a
   // limit bounce, which keeps going the same way through the switch; the index seek keeps the last direction.
   always_comb begin
      state_next      = state_reg;
      dir_next        = dir_reg;
      limit_path_next = limit_path_reg;
      unique case (state_reg)
         HS_IDLE: begin
            if (i_homing_start && method_ok) begin
               limit_path_next = 1'b0;
               if (decel_level) begin
                  state_next = HS_SLOW1;
                  dir_next   = ~fast_reverse;
               end else begin
                  state_next = HS_FAST;
                  dir_next   = fast_reverse;
               end
            end
         end
         HS_FAST: begin
            if (watch_limit && rise[HS_IN_POS]) begin
               state_next      = HS_LIMIT_REV;
               dir_next        = 1'b1;
               limit_path_next = 1'b1;
            end else if (decel_rise) begin
               state_next = HS_SLOW1;
               dir_next   = ~dir_reg;
            end
         end
         HS_LIMIT_REV: begin
            if (rise[HS_IN_HOME]) begin
               state_next = HS_SLOW1;
            end
         end
         HS_SLOW1: begin
            if (decel_fall) begin
               if (two_stage) begin
                  state_next = HS_SLOW2;
                  dir_next   = ~dir_reg;
               end else begin
                  state_next = HS_SEEK;
               end
            end
         end
         HS_SLOW2: begin
            if (rise[HS_IN_HOME]) begin
               if (watch_limit && limit_path_reg && i_homing_method_select != HS_METHOD_HOME_LIM_2) begin
                  state_next = HS_SLOW3;
                  dir_next   = ~dir_reg;
               end else begin
                  state_next = HS_SEEK;
               end
            end
         end
         HS_SLOW3: begin
            if (fall[HS_IN_HOME]) begin
               state_next = HS_SEEK;
            end
         end
         HS_SEEK: begin
            if (rise[HS_IN_INDEX]) begin
               state_next = HS_IDLE;
            end
         end
      endcase
      if (i_homing_abort) begin
         state_next = HS_IDLE;
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg      <= HS_IDLE;
         dir_reg        <= 1'b0;
         limit_path_reg <= 1'b0;
      end else if (i_clock_en) begin
         state_reg      <= state_next;
         dir_reg        <= dir_next;
         limit_path_reg <= limit_path_next;
      end
   end

   // Done stays up until the next start; error flags an unsupported method.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         done_reg  <= 1'b0;
         error_reg <= 1'b0;
      end else if (i_clock_en) begin
         if (state_reg == HS_SEEK && rise[HS_IN_INDEX] && !i_homing_abort) begin
            done_reg <= 1'b1;
         end else if (state_reg == HS_IDLE && i_homing_start) begin
            done_reg <= 1'b0;
         end
         if (state_reg == HS_IDLE && i_homing_start) begin
            error_reg <= ~method_ok;
         end
      end
   end

   // -----------------------------------------------------------------
   // Motion reference outputs
   // -----------------------------------------------------------------
   assign ceiling_hit = (i_profile_acceleration > accel_ceiling_reg);

   // The speed lags the state by one cycle; the ramp limit smooths the step anyway.
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_speed_ref           <= HS_ZERO_WORD;
         o_dir_reverse         <= 1'b0;
         o_homing_acceleration <= HS_ACCEL_CEILING_RESET;
      end else if (i_clock_en) begin
         o_dir_reverse <= dir_reg;
         unique case (state_reg)
            HS_FAST, HS_LIMIT_REV: o_speed_ref <= i_switch_search_speed;
            HS_SLOW1, HS_SLOW2, HS_SLOW3, HS_SEEK: o_speed_ref <= i_index_search_speed;
            HS_IDLE: o_speed_ref <= HS_ZERO_WORD;
         endcase
         if (ceiling_hit) begin
            o_homing_acceleration <= accel_ceiling_reg;
         end else begin
            o_homing_acceleration <= i_profile_acceleration;
         end
      end
   end

   assign o_homing_active = (state_reg != HS_IDLE);
   assign o_homing_done   = done_reg;
   assign o_method_error  = error_reg;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   sequence seek_index_s;
      i_clock_en && state_reg == HS_SEEK && rise[HS_IN_INDEX] && !i_homing_abort;
   endsequence

   sequence fast_turn_s;
      i_clock_en && state_reg == HS_FAST && decel_rise && !(watch_limit && rise[HS_IN_POS]) && !i_homing_abort;
   endsequence

   ceiling_clamp_a: assert property (i_clock_en && ceiling_hit |=> o_homing_acceleration == $past(accel_ceiling_reg))
      else $error("ceiling not applied to acceleration");

   zero_write_a: assert property (i_clock_en && i_obj_write && obj_sel && i_obj_wdata == HS_ZERO_WORD
                                  |=> accel_ceiling_reg == HS_ACCEL_CEILING_MIN ##1 o_accel_ceiling != HS_ZERO_WORD)
      else $error("zero ceiling not replaced by one");

   ceiling_write_a: assert property (i_clock_en && i_obj_write && obj_sel && i_obj_wdata != HS_ZERO_WORD
                                     |=> o_accel_ceiling == $past(i_obj_wdata))
      else $error("ceiling write not effective immediately");

   fast_speed_a: assert property (i_clock_en && state_reg == HS_FAST |=> o_speed_ref == $past(i_switch_search_speed))
      else $error("fast search not at switch search speed");

   fast_turn_a: assert property (fast_turn_s |=> state_reg == HS_SLOW1 && dir_reg != $past(dir_reg))
      else $error("no slow reverse at deceleration edge");

   active_start_a: assert property (i_clock_en && state_reg == HS_IDLE && i_homing_start && method_ok && decel_level
                                    && !i_homing_abort |=> state_reg == HS_SLOW1 && dir_reg == !$past(fast_reverse))
      else $error("active start did not begin slow pass");

   limit_bounce_a: assert property (i_clock_en && state_reg == HS_FAST && watch_limit && rise[HS_IN_POS]
                                    && !i_homing_abort |=> state_reg == HS_LIMIT_REV && dir_reg)
      else $error("positive limit did not reverse the search");

   index_stop_a: assert property (seek_index_s |=> o_homing_done && !o_homing_active
                                  ##1 (o_speed_ref == HS_ZERO_WORD || !$past(i_clock_en)))
      else $error("index pulse did not stop homing");

   second_pass_a: assert property (i_clock_en && state_reg == HS_SLOW1 && decel_fall && two_stage && !i_homing_abort
                                   |=> state_reg == HS_SLOW2)
      else $error("second slow pass missing");

   edge_once_a: assert property (rise[HS_IN_HOME] && i_clock_en |=> !rise[HS_IN_HOME])
      else $error("switch edge seen twice");

endmodule

// ---- shared/hs_pkg.sv ----
package hs_pkg;

   // -----------------------------------------------------------------
   // Object dictionary entries held by the block
   // -----------------------------------------------------------------
   localparam logic [15:0] HS_ACCEL_CEILING_INDEX = 16'h60C5;
   localparam logic [31:0] HS_ACCEL_CEILING_RESET = 32'h7FFFFFFF;
   localparam logic [31:0] HS_ACCEL_CEILING_MIN   = 32'h00000001;
   localparam logic [31:0] HS_ZERO_WORD           = 32'h00000000;

   // -----------------------------------------------------------------
   // Homing method codes
   // -----------------------------------------------------------------
   localparam logic [7:0] HS_METHOD_NEG_LIMIT   = 8'h01;
   localparam logic [7:0] HS_METHOD_POS_LIMIT   = 8'h02;
   localparam logic [7:0] HS_METHOD_HOME_FWD    = 8'h03;
   localparam logic [7:0] HS_METHOD_HOME_FWD_2  = 8'h04;
   localparam logic [7:0] HS_METHOD_HOME_REV    = 8'h05;
   localparam logic [7:0] HS_METHOD_HOME_REV_2  = 8'h06;
   localparam logic [7:0] HS_METHOD_HOME_LIM    = 8'h07;
   localparam logic [7:0] HS_METHOD_HOME_LIM_2  = 8'h08;

   // -----------------------------------------------------------------
   // Input synchroniser layout and sequence states
   // -----------------------------------------------------------------
   localparam int HS_IN_NEG   = 0;
   localparam int HS_IN_POS   = 1;
   localparam int HS_IN_HOME  = 2;
   localparam int HS_IN_INDEX = 3;
   localparam int HS_IN_COUNT = 4;
   localparam logic [HS_IN_COUNT-1:0] HS_IN_RESET = 4'h0;

   typedef enum logic [2:0] {
      HS_IDLE,
      HS_FAST,
      HS_LIMIT_REV,
      HS_SLOW1,
      HS_SLOW2,
      HS_SLOW3,
      HS_SEEK
   } hs_state_type;

endpackage
